// ---- logic/nvsc_host.v ----
// Host controller driving a nonvolatile SRAM over its asynchronous pins.
// Assumes the device pins are asynchronous to clk_i; store_busy_n is open drain.
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_defs.vh"
module nvsc_host #(
    parameter STORE_CYC = `NVSC_STORE_CYC,
    parameter DELAY_CYC = `NVSC_DELAY_CYC,
    parameter RECALL_CYC = `NVSC_RECALL_CYC,
    parameter PUREC_CYC = `NVSC_PUREC_CYC,
    parameter ACC_CYC = `NVSC_ACC_CYC
) (
    input wire clk_i,
    input wire rst_i,
    // User command port
    input wire cmd_valid_i,
    input wire [1:0] cmd_op_i,
    input wire [12:0] cmd_addr_i,
    input wire [7:0] cmd_wdata_i,
    input wire hw_store_i,
    output reg cmd_ready_o,
    output reg rsp_valid_o,
    output reg [7:0] rsp_rdata_o,
    output reg nv_busy_o,
    // Device pins
    output reg [12:0] addr_o,
    output reg [7:0] dq_o,
    output reg dq_oe_o,
    input wire [7:0] dq_i,
    output reg chip_sel_n_o,
    output reg write_n_o,
    output reg out_gate_n_o,
    output reg store_busy_n_o,
    output reg store_busy_oe_o,
    input wire store_busy_n_i,
    input wire below_trip_i
);
    // ***********************************************
    // Synchronisers
    // ***********************************************
    reg busy_m, busy_s, trip_m, trip_s, busy_d;
    reg [7:0] dq_m, dq_s;
    // Two flops on every pin input before use
    always @(posedge clk_i)
    begin
        busy_m <= store_busy_n_i;
        busy_s <= busy_m;
        trip_m <= below_trip_i;
        trip_s <= trip_m;
        dq_m <= dq_i;
        dq_s <= dq_m;
        busy_d <= rst_i ? 1'b1 : busy_s;
    end

    // ***********************************************
    // State machine
    // ***********************************************
    localparam S_IDLE = 4'h0;
    localparam S_ACC = 4'h1;
    localparam S_GAP = 4'h2;
    localparam S_REQ = 4'h3;
    localparam S_HWAIT = 4'h4;
    localparam S_SWAIT = 4'h5;
    localparam S_RWAIT = 4'h6;
    localparam S_PWAIT = 4'h7;
    localparam S_REL = 4'h8;
    localparam TW = 24;

    reg [3:0] state;
    reg [1:0] op;
    reg [2:0] step;
    reg [12:0] addr_r;
    reg tload;
    reg [TW-1:0] tcount;
    wire tdone;

    nvsc_timer #(.W(TW)) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(tload),
        .count_i(tcount),
        .done_o(tdone)
    );

    // Address of each step of the six-read unlock sequence
    function [12:0] seq_addr;
        input [2:0] s;
        input is_store;
        begin
            case (s)
                3'h0: seq_addr = `NVSC_SEQ_A0;
                3'h1: seq_addr = `NVSC_SEQ_A1;
                3'h2: seq_addr = `NVSC_SEQ_A2;
                3'h3: seq_addr = `NVSC_SEQ_A3;
                3'h4: seq_addr = `NVSC_SEQ_A4;
                default: seq_addr = is_store ? `NVSC_SEQ_STORE : `NVSC_SEQ_RECALL;
            endcase
        end
    endfunction

    // Truncated cycle counts, widths fixed to the timer
    function [TW-1:0] cyc;
        input integer n;
        begin
            cyc = n[TW-1:0];
        end
    endfunction

    wire is_seq = (op == `NVSC_CMD_SWSTORE) || (op == `NVSC_CMD_SWRECALL);

    // Main sequencer; all pin outputs registered
    always @(posedge clk_i)
    begin
        tload <= 1'b0;
        tcount <= tcount;
        rsp_valid_o <= 1'b0;
        if (rst_i)
        begin
            state <= S_PWAIT;
            op <= `NVSC_CMD_READ;
            step <= 3'h0;
            addr_r <= 13'h0000;
            // Power-up recall wait is armed so it starts as reset lifts
            tcount <= cyc(PUREC_CYC);
            tload <= 1'b1;
            cmd_ready_o <= 1'b0;
            rsp_rdata_o <= 8'h00;
            nv_busy_o <= 1'b1;
            addr_o <= 13'h0000;
            dq_o <= 8'h00;
            dq_oe_o <= 1'b0;
            chip_sel_n_o <= 1'b1;
            write_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            store_busy_n_o <= 1'b1;
            store_busy_oe_o <= 1'b0;
        end
        else
        begin
            case (state)
                S_PWAIT:
                begin
                    if (trip_s)
                    begin
                        tload <= 1'b1;
                        tcount <= cyc(PUREC_CYC);
                    end
                    else if (tdone && !tload)
                    begin
                        state <= S_IDLE;
                        cmd_ready_o <= 1'b1;
                        nv_busy_o <= 1'b0;
                    end
                end
                S_IDLE:
                begin
                    // device storing on supply loss; wait it out
                    if (trip_s)
                    begin
                        state <= S_PWAIT;
                        cmd_ready_o <= 1'b0;
                        nv_busy_o <= 1'b1;
                        tload <= 1'b1;
                        tcount <= cyc(PUREC_CYC);
                    end
                    // device-driven busy: host stays off the bus
                    else if (!busy_s)
                    begin
                        state <= S_HWAIT;
                        cmd_ready_o <= 1'b0;
                        nv_busy_o <= 1'b1;
                    end
                    // pin store request, open-drain pulled low
                    else if (hw_store_i)
                    begin
                        state <= S_REQ;
                        cmd_ready_o <= 1'b0;
                        nv_busy_o <= 1'b1;
                        store_busy_n_o <= 1'b0;
                        store_busy_oe_o <= 1'b1;
                        tload <= 1'b1;
                        tcount <= cyc(DELAY_CYC);
                    end
                    else if (cmd_valid_i)
                    begin
                        cmd_ready_o <= 1'b0;
                        op <= cmd_op_i;
                        step <= 3'h0;
                        addr_r <= cmd_addr_i;
                        if (cmd_op_i == `NVSC_CMD_WRITE && trip_s)
                        begin
                            rsp_valid_o <= 1'b1;
                            cmd_ready_o <= 1'b1;
                        end
                        else
                        begin
                            state <= S_ACC;
                            nv_busy_o <= (cmd_op_i[1] == 1'b1);
                            addr_o <= cmd_op_i[1] ? seq_addr(3'h0, 1'b0) : cmd_addr_i;
                            chip_sel_n_o <= 1'b0;
                            // write with chip select and strobe low
                            write_n_o <= (cmd_op_i != `NVSC_CMD_WRITE);
                            out_gate_n_o <= (cmd_op_i == `NVSC_CMD_WRITE);
                            dq_o <= cmd_wdata_i;
                            dq_oe_o <= (cmd_op_i == `NVSC_CMD_WRITE);
                            tload <= 1'b1;
                            tcount <= cyc(ACC_CYC);
                        end
                    end
                end
                // One access, ended by chip select rising
                S_ACC:
                begin
                    if (tdone && !tload)
                    begin
                        if (!is_seq)
                            rsp_rdata_o <= dq_s;
                        chip_sel_n_o <= 1'b1;
                        write_n_o <= 1'b1;
                        out_gate_n_o <= 1'b1;
                        dq_oe_o <= 1'b0;
                        state <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    // sequence reads issued back to back, nothing between
                    if (is_seq && step != 3'h5)
                    begin
                        step <= step + 3'h1;
                        // sixth address picks store or recall
                        addr_o <= seq_addr(step + 3'h1, op == `NVSC_CMD_SWSTORE);
                        chip_sel_n_o <= 1'b0;
                        // chip-select controlled, gate left high on sixth
                        out_gate_n_o <= (step == 3'h4);
                        tload <= 1'b1;
                        tcount <= cyc(ACC_CYC);
                        state <= S_ACC;
                    end
                    else if (op == `NVSC_CMD_SWSTORE)
                    begin
                        // store always runs; wait store cycle time
                        tload <= 1'b1;
                        tcount <= cyc(STORE_CYC);
                        state <= S_SWAIT;
                    end
                    else if (op == `NVSC_CMD_SWRECALL)
                    begin
                        tload <= 1'b1;
                        tcount <= cyc(RECALL_CYC);
                        state <= S_RWAIT;
                    end
                    else
                    begin
                        rsp_valid_o <= 1'b1;
                        state <= S_REL;
                    end
                end
                // hold request through the store request delay
                S_REQ:
                begin
                    if (tdone && !tload)
                    begin
                        // device may skip; store time covers worst case
                        store_busy_n_o <= 1'b1;
                        store_busy_oe_o <= 1'b0;
                        tload <= 1'b1;
                        tcount <= cyc(STORE_CYC);
                        state <= S_HWAIT;
                    end
                end
                // stay off until busy seen high again
                S_HWAIT:
                begin
                    if (busy_s && busy_d && tdone && !tload)
                        state <= S_REL;
                end
                S_SWAIT, S_RWAIT:
                begin
                    if (tdone && !tload && busy_s)
                    begin
                        rsp_valid_o <= 1'b1;
                        state <= S_REL;
                    end
                end
                // strobes already high, so no held write crosses the end
                S_REL:
                begin
                    state <= S_IDLE;
                    cmd_ready_o <= 1'b1;
                    nv_busy_o <= 1'b0;
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
    // mode strap lives at the device; times are parameters
endmodule // nvsc_host
`default_nettype wire

// ---- logic/nvsc_defs.vh ----
// Constants for the nonvolatile SRAM host-side controller.
// Assumes a 25 MHz clock and the device's asynchronous SRAM pins.
`ifndef NVSC_DEFS_VH
`define NVSC_DEFS_VH
`define NVSC_SEQ_A0 13'h0000
`define NVSC_SEQ_A1 13'h1555
`define NVSC_SEQ_A2 13'h0AAA
`define NVSC_SEQ_A3 13'h1FFF
`define NVSC_SEQ_A4 13'h10F0
`define NVSC_SEQ_STORE 13'h0F0F
`define NVSC_SEQ_RECALL 13'h0F0E
`define NVSC_CLK_MHZ 25
`define NVSC_STORE_MS 10
`define NVSC_STORE_CYC (`NVSC_STORE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_DELAY_CYC 64
`define NVSC_RECALL_CYC 512
`define NVSC_PUREC_CYC 1024
`define NVSC_ACC_CYC 3
`define NVSC_CMD_READ 2'h0
`define NVSC_CMD_WRITE 2'h1
`define NVSC_CMD_SWSTORE 2'h2
`define NVSC_CMD_SWRECALL 2'h3
`endif

// ---- logic/nvsc_timer.v ----
// Down-counting wait timer for the host controller.
// Assumes a load pulse with a nonzero count; same clock as the user.
`timescale 1ns/1ps
`default_nettype none
module nvsc_timer #(
    parameter W = 24
) (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire [W-1:0] count_i,
    output wire done_o
);
    reg [W-1:0] cnt;
    // Counts to zero; a reload restarts the wait
    always @(posedge clk_i)
    begin
        if (rst_i)
            cnt <= {W{1'b0}};
        else if (load_i)
            cnt <= count_i;
        else if (cnt != {W{1'b0}})
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end
    assign done_o = (cnt == {W{1'b0}}) & ~load_i;
endmodule // nvsc_timer
`default_nettype wire

// ---- test/nvsc_host_checker.sv ----
// Assertions on the pins of the nonvolatile SRAM host controller.
// Assumes binding into nvsc_host; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic hw_store_i,
    input wire logic cmd_ready_o,
    input wire logic rsp_valid_o,
    input wire logic [12:0] addr_o,
    input wire logic dq_oe_o,
    input wire logic chip_sel_n_o,
    input wire logic write_n_o,
    input wire logic out_gate_n_o,
    input wire logic store_busy_n_o,
    input wire logic store_busy_oe_o,
    input wire logic store_busy_n_i,
    input wire logic below_trip_i
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Pins calm long enough for the input synchronisers
    sequence calm_s;
        (store_busy_n_i && !below_trip_i)[*4];
    endsequence
    sequence hold_s;
        (!chip_sel_n_o && $stable(addr_o))[*3];
    endsequence
    quiet_rst_a: assert property (disable iff (1'b0)
        rst_i |=> chip_sel_n_o && write_n_o && !dq_oe_o && !store_busy_oe_o)
        else $error("pins active in reset");
    pwr_wait_a: assert property ($fell(rst_i) |-> !cmd_ready_o[*8])
        else $error("ready before recall wait");
    take_cmd_a: assert property (
        calm_s ##0 (cmd_ready_o && cmd_valid_i && !hw_store_i) |=> !cmd_ready_o)
        else $error("command not taken");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o ##[0:2] cmd_ready_o)
        else $error("response not one cycle");
    addr_hold_a: assert property ($fell(chip_sel_n_o) |=> hold_s)
        else $error("access too short");
    wr_drive_a: assert property (!chip_sel_n_o && !write_n_o |-> dq_oe_o && out_gate_n_o)
        else $error("write without data");
    rd_bus_a: assert property (!out_gate_n_o |-> !dq_oe_o && write_n_o)
        else $error("bus fight on read");
    pull_low_a: assert property (store_busy_oe_o |-> !store_busy_n_o && write_n_o)
        else $error("bad busy pull");
    store_idle_a: assert property ($fell(store_busy_oe_o) |-> chip_sel_n_o[*8])
        else $error("access during store");
    trip_write_a: assert property (below_trip_i[*8] |-> write_n_o)
        else $error("write at low supply");
    busy_write_a: assert property (!store_busy_n_i[*8] |-> write_n_o)
        else $error("write while busy");
endmodule // nvsc_host_checker
bind nvsc_host nvsc_host_checker u_chk (.*);
`default_nettype wire

// ---- test/nvsc_dev_model.sv ----
// Behavioural nonvolatile SRAM as seen on the host pins.
// Assumes clk_i samples the access pins and paces its timers; busy line resolved outside.
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model #(
    parameter DLY = 6,
    parameter XFER = 40
) (
    input wire logic clk_i,
    input wire logic [12:0] addr_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    input wire logic chip_sel_n_i,
    input wire logic write_n_i,
    input wire logic out_gate_n_i,
    input wire logic busy_lvl_i,
    output logic busy_pull_o,
    input wire logic below_trip_i,
    input wire logic inhibit_i
);
    logic [7:0] mem [0:8191];
    logic [7:0] nv [0:8191];
    logic [12:0] sq [0:4] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
    logic [12:0] a_q;
    logic [7:0] d_q, last_q = 8'h00;
    logic w_q = 1'b1, cs_q = 1'b1, dirty = 1'b0, trip_q = 1'b0, st = 1'b0, rd;
    int step = 0, cnt = 0, hcnt = 0;
    // ****
    // Array behaviour
    // ****
    // data only on a real read, else a changed level
    assign rd = !chip_sel_n_i && write_n_i && !out_gate_n_i && busy_lvl_i && cnt == 0;
    assign dq_o = rd ? mem[addr_i] : ~last_q;
    // busy pulled for the whole store
    assign busy_pull_o = cnt != 0 && st;
    // copy at once, then stay busy for the cycle time
    task automatic start(input logic s);
        for (int i = 0; i < 8192; i++)
            if (s) nv[i] = mem[i]; else mem[i] = nv[i];
        cnt <= XFER;
        st <= s;
        dirty <= 1'b0;
    endtask
    // Accesses complete at the rising chip select
    always @(posedge clk_i)
    begin
        cs_q <= chip_sel_n_i;
        trip_q <= below_trip_i;
        if (rd) last_q <= mem[addr_i];
        if (!chip_sel_n_i) {a_q, d_q, w_q} <= {addr_i, dq_i, write_n_i};
        if (busy_lvl_i) hcnt <= 0;
        if (cnt != 0) cnt <= cnt - 1;
        // write lands, any write breaks the sequence
        else if (chip_sel_n_i && !cs_q && !w_q)
        begin
            if (busy_lvl_i && !below_trip_i) {mem[a_q], dirty} <= {d_q, 1'b1};
            step <= 0;
        end
        // reads step the sequence, output gate ignored
        else if (chip_sel_n_i && !cs_q)
        begin
            if (step == 5 && a_q[12:1] == 12'h787) start(a_q[0]);
            if (step < 5 && a_q == sq[step]) step <= step + 1;
            else step <= int'(a_q == 13'h0000);
        end
        // pin request after the delay, only when dirty
        else if (!busy_lvl_i && !below_trip_i)
        begin
            hcnt <= hcnt + 1;
            if (hcnt == DLY && dirty) start(1'b1);
        end
        // power loss store unless the static strap inhibits it
        else if (below_trip_i && !trip_q && !inhibit_i && dirty) start(1'b1);
    end
endmodule // nvsc_dev_model
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench: nvsc_host driving the behavioural device.
// Assumes the device model and the bound checker compile first.
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_defs.vh"
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, hw_store_i = 1'b0, below = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [12:0] cmd_addr_i = 13'h0000;
    logic [7:0] cmd_wdata_i = 8'h00;
    wire logic rdy, rsp, nvb, dq_oe, cs_n, we_n, og_n, sb_n, sb_oe, pull, sb_lvl;
    wire logic [7:0] rdata, dq_h, dq_d;
    wire logic [12:0] addr;
    logic [8:0] exp_q [$];
    logic [8:0] e;
    logic [12:0] a [0:3];
    logic [7:0] d [0:3];
    logic [31:0] seed = 32'hC8375288;
    int err_count = 0, checks = 0, cyc = 0;
    // Open-drain busy line with its pull-up
    assign sb_lvl = !(sb_oe && !sb_n) && !pull;
    always #20 clk_i = ~clk_i;
    // Short transfer times keep the run brief
    nvsc_host #(.STORE_CYC(50), .DELAY_CYC(10), .RECALL_CYC(50), .PUREC_CYC(16))
        u_dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
        .hw_store_i(hw_store_i), .cmd_ready_o(rdy), .rsp_valid_o(rsp),
        .rsp_rdata_o(rdata), .nv_busy_o(nvb), .addr_o(addr), .dq_o(dq_h),
        .dq_oe_o(dq_oe), .dq_i(dq_d), .chip_sel_n_o(cs_n), .write_n_o(we_n),
        .out_gate_n_o(og_n), .store_busy_n_o(sb_n), .store_busy_oe_o(sb_oe),
        .store_busy_n_i(sb_lvl), .below_trip_i(below));
    nvsc_dev_model u_dev (.clk_i(clk_i), .addr_i(addr), .dq_i(dq_h), .dq_o(dq_d),
        .chip_sel_n_i(cs_n), .write_n_i(we_n), .out_gate_n_i(og_n), .busy_lvl_i(sb_lvl),
        .busy_pull_o(pull), .below_trip_i(below), .inhibit_i(1'b0));
    // ****
    // Tasks
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict;
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_ready;
        int n = 0;
        do @(posedge clk_i); while (rdy !== 1'b1 && ++n < 600);
        // A controller that never comes back to idle is a failure
        if (rdy !== 1'b1)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rdy, 1'b1);
        end
        #1;
    endtask
    // One command; reads note the byte they must return
    task automatic cmd(input logic [1:0] op, input logic [12:0] ad, input logic [7:0] wd,
        input logic [7:0] ex);
        int n = 0;
        wait_ready();
        exp_q.push_back({op == `NVSC_CMD_READ, ex});
        {cmd_op_i, cmd_addr_i, cmd_wdata_i, cmd_valid_i} = {op, ad, wd, 1'b1};
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b0;
        do @(posedge clk_i); while (rsp !== 1'b1 && ++n < 600);
        // A command left unanswered is a failure
        if (rsp !== 1'b1)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rsp, 1'b1);
        end
        // Leave the edge before anyone changes an input
        #1;
    endtask
    // Oldest note against each response; a stray response always mismatches
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000) err_count++;
        if (cyc == 20000) print_verdict();
        if (rsp === 1'b1)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : {1'b1, ~rdata};
            checks += int'(e[8]);
            if (e[8] && rdata !== e[7:0])
            begin
                err_count++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, e[7:0]);
            end
        end
    end
    // ****
    // Scenarios
    // ****
    initial
    begin
        repeat (12) @(posedge clk_i);
        #1 rst_i = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            a[i] = {i[1:0], seed[10:0]};
            d[i] = seed[18:11];
            cmd(`NVSC_CMD_WRITE, a[i], d[i], 8'h00);
        end
        for (int i = 0; i < 4; i++) cmd(`NVSC_CMD_READ, a[i], 8'h00, d[i]);
        cmd(`NVSC_CMD_SWSTORE, 13'h0000, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) cmd(`NVSC_CMD_WRITE, a[i], ~d[i], 8'h00);
        cmd(`NVSC_CMD_READ, a[0], 8'h00, ~d[0]);
        cmd(`NVSC_CMD_SWRECALL, 13'h0000, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) cmd(`NVSC_CMD_READ, a[i], 8'h00, d[i]);
        // Pin store keeps 5A; the later write is rolled back by a recall
        cmd(`NVSC_CMD_WRITE, a[0], 8'h5A, 8'h00);
        wait_ready();
        hw_store_i = 1'b1;
        @(posedge clk_i);
        #1 hw_store_i = 1'b0;
        cmd(`NVSC_CMD_WRITE, a[0], 8'hA5, 8'h00);
        cmd(`NVSC_CMD_SWRECALL, 13'h0000, 8'h00, 8'h00);
        cmd(`NVSC_CMD_READ, a[0], 8'h00, 8'h5A);
        // Low supply: the write may be answered or ignored, never stored
        below = 1'b1;
        cmd(`NVSC_CMD_WRITE, a[1], 8'h3C, 8'h00);
        exp_q.delete();
        below = 1'b0;
        // Let the synchronised trip level reach the controller before offering
        repeat (4) @(posedge clk_i);
        cmd(`NVSC_CMD_READ, a[1], 8'h00, d[1]);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
